// ### hw/serial_port_irq_dma_ctrl_cfg.svh
// register offsets, field positions, reset values and limits of the serial port irq/dma block
// assumes a 32-bit apb with word-aligned registers
`ifndef SERIAL_PORT_IRQ_DMA_CTRL_CFG_SVH
`define SERIAL_PORT_IRQ_DMA_CTRL_CFG_SVH

`define SPC_ADDR_W          12
`define SPC_OFS_CTRL        12'h000
`define SPC_OFS_DMA_EN      12'h004
`define SPC_OFS_DMA_SET     12'h008
`define SPC_OFS_DMA_CLR     12'h00c
`define SPC_OFS_IRQ_RAW     12'h010
`define SPC_OFS_IRQ_MASK    12'h014
`define SPC_OFS_IRQ_MASKED  12'h018
`define SPC_OFS_IRQ_CLEAR   12'h01c
`define SPC_OFS_STATUS      12'h020
`define SPC_OFS_TX_DATA     12'h024
`define SPC_OFS_RX_DATA     12'h028

`define SPC_CTRL_EN_BIT     0
`define SPC_CTRL_WID_LSB    4
`define SPC_CTRL_WID_MSB    7
`define SPC_STAT_BUSY_BIT   0
`define SPC_STAT_EN_BIT     1

`define SPC_IRQ_TX_FIFO     0
`define SPC_IRQ_RX_FIFO     1
`define SPC_IRQ_RX_TIMEOUT  2
`define SPC_IRQ_RX_OVERRUN  3

`define SPC_RST_WID_M1      4'h7
`define SPC_RST_MASK        4'h0
`define SPC_RST_DMA         2'h0
`define SPC_WID_MIN_M1      4'h3
`define SPC_WORD_W          16

`endif

// ### hw/serial_port_irq_dma_pkg.sv
// types shared by the serial port irq/dma control block
// assumes the cfg header fixes the bit positions that these structs mirror
package serial_port_irq_dma_pkg;

    // bit 0 tx fifo, bit 1 rx fifo, bit 2 rx timeout, bit 3 rx overrun
    typedef struct packed {
        logic rx_overrun_irq;
        logic rx_timeout_irq;
        logic rx_fifo_service_irq;
        logic tx_fifo_service_irq;
    } irq_vec_s;

    // bit 0 receive, bit 1 transmit
    typedef struct packed {
        logic tx_dma_enable;
        logic rx_dma_enable;
    } dma_en_s;

    typedef enum logic {
        APB_IDLE,
        APB_ACK
    } apb_phase_e;

endpackage

// ### hw/serial_port_irq_dma_ctrl.sv
// interrupt, dma request enable and port enable control of a sync serial port, apb slave
// assumes the shifter datapath and fifos sit on the same clock and drive the status inputs
//
// Behaviour
// - separate independent rx and tx dma enables
// - dma disable clears only the named enables
// - one control bit enables/disables the port
// - four interrupt status bits in one field
// - per-source mask gates the interrupt output
// - raw and masked status both readable
// - write-one clear only for timeout and overrun
// - busy unless tx fifo and shifter empty
// - frame width 4..16, excess bits dropped
`include "serial_port_irq_dma_ctrl_cfg.svh"

module serial_port_irq_dma_ctrl #(
    parameter int WORD_W = `SPC_WORD_W
) (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SPC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   tx_fifo_req,
    input  wire logic                   rx_fifo_req,
    input  wire logic                   rx_timeout_evt,
    input  wire logic                   rx_overrun_evt,
    input  wire logic                   tx_fifo_empty,
    input  wire logic                   shift_empty,
    input  wire logic [WORD_W-1:0]      rx_word,
    output logic                        rx_word_pop,
    output logic      [WORD_W-1:0]      tx_word,
    output logic                        tx_word_valid,
    output logic                        port_enable,
    output logic      [3:0]             width_m1,
    output logic                        rx_dma_enable,
    output logic                        tx_dma_enable,
    output logic                        busy,
    output logic                        irq
);

    // low width_m1+1 bits set
    function automatic logic [WORD_W-1:0] width_mask(input logic [3:0] wm1);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (i <= int'(wm1)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    serial_port_irq_dma_pkg::apb_phase_e phase_reg;
    serial_port_irq_dma_pkg::apb_phase_e phase_next;
    serial_port_irq_dma_pkg::irq_vec_s   raw_reg;
    serial_port_irq_dma_pkg::irq_vec_s   raw_next;
    serial_port_irq_dma_pkg::irq_vec_s   mask_reg;
    serial_port_irq_dma_pkg::irq_vec_s   masked;
    serial_port_irq_dma_pkg::irq_vec_s   clr_sel;
    serial_port_irq_dma_pkg::dma_en_s    dma_reg;
    serial_port_irq_dma_pkg::dma_en_s    dma_next;

    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              port_en_reg;
    logic [3:0]        wid_reg;
    logic [3:0]        wid_next;
    logic              busy_reg;
    logic              irq_reg;
    logic [WORD_W-1:0] tx_word_reg;
    logic              tx_valid_reg;
    logic              rx_pop_reg;

    wire               access    = psel && penable;
    wire               commit    = access && pready_reg;
    wire               wr_commit = commit && pwrite;
    wire               rd_commit = commit && !pwrite;
    wire [WORD_W-1:0]  wmask     = width_mask(wid_reg);

    wire hit_ctrl    = (paddr == `SPC_OFS_CTRL);
    wire hit_dma     = (paddr == `SPC_OFS_DMA_EN);
    wire hit_dma_set = (paddr == `SPC_OFS_DMA_SET);
    wire hit_dma_clr = (paddr == `SPC_OFS_DMA_CLR);
    wire hit_raw     = (paddr == `SPC_OFS_IRQ_RAW);
    wire hit_mask    = (paddr == `SPC_OFS_IRQ_MASK);
    wire hit_masked  = (paddr == `SPC_OFS_IRQ_MASKED);
    wire hit_clear   = (paddr == `SPC_OFS_IRQ_CLEAR);
    wire hit_status  = (paddr == `SPC_OFS_STATUS);
    wire hit_tx      = (paddr == `SPC_OFS_TX_DATA);
    wire hit_rx      = (paddr == `SPC_OFS_RX_DATA);
    wire mapped      = hit_ctrl || hit_dma || hit_dma_set || hit_dma_clr || hit_raw
                       || hit_mask || hit_masked || hit_clear || hit_status || hit_tx || hit_rx;

    // apb: first access cycle waits, pready rises on the second
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            serial_port_irq_dma_pkg::APB_IDLE: begin
                if (access) begin
                    phase_next = serial_port_irq_dma_pkg::APB_ACK;
                end
            end
            serial_port_irq_dma_pkg::APB_ACK: begin
                phase_next = serial_port_irq_dma_pkg::APB_IDLE;
            end
            default: begin
                phase_next = serial_port_irq_dma_pkg::APB_IDLE;
            end
        endcase
    end

    wire ack_now = (phase_reg == serial_port_irq_dma_pkg::APB_IDLE) && access;

    // read mux; write-only registers read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[`SPC_CTRL_EN_BIT] = port_en_reg;
            rd_mux[`SPC_CTRL_WID_MSB:`SPC_CTRL_WID_LSB] = wid_reg;
        end else if (hit_dma) begin
            rd_mux[1:0] = dma_reg;
        end else if (hit_raw) begin
            rd_mux[3:0] = raw_reg;
        end else if (hit_mask) begin
            rd_mux[3:0] = mask_reg;
        end else if (hit_masked) begin
            rd_mux[3:0] = masked;
        end else if (hit_status) begin
            rd_mux[`SPC_STAT_BUSY_BIT] = busy_reg;
            rd_mux[`SPC_STAT_EN_BIT]   = port_en_reg;
        end else if (hit_rx) begin
            rd_mux[WORD_W-1:0] = rx_word & wmask;
        end
    end

    // dma enables: set and clear act only on named bits
    always_comb begin
        dma_next = dma_reg;
        if (wr_commit && hit_dma) begin
            dma_next = pwdata[1:0];
        end else if (wr_commit && hit_dma_set) begin
            dma_next = dma_reg | pwdata[1:0];
        end else if (wr_commit && hit_dma_clr) begin
            dma_next = dma_reg & ~pwdata[1:0];
        end
    end

    // width field below the minimum is clamped rather than refused
    wire [3:0] wid_wr = pwdata[`SPC_CTRL_WID_MSB:`SPC_CTRL_WID_LSB];
    assign wid_next = (wid_wr < `SPC_WID_MIN_M1) ? `SPC_WID_MIN_M1 : wid_wr;

    // only timeout and overrun can be cleared; a new event beats the clear
    always_comb begin
        clr_sel = '0;
        if (wr_commit && hit_clear) begin
            clr_sel.rx_timeout_irq = pwdata[`SPC_IRQ_RX_TIMEOUT];
            clr_sel.rx_overrun_irq = pwdata[`SPC_IRQ_RX_OVERRUN];
        end
    end

    always_comb begin
        raw_next = raw_reg;
        raw_next.tx_fifo_service_irq = tx_fifo_req;
        raw_next.rx_fifo_service_irq = rx_fifo_req;
        raw_next.rx_timeout_irq = rx_timeout_evt
                                  || (raw_reg.rx_timeout_irq && !clr_sel.rx_timeout_irq);
        raw_next.rx_overrun_irq = rx_overrun_evt
                                  || (raw_reg.rx_overrun_irq && !clr_sel.rx_overrun_irq);
    end

    assign masked = raw_reg & mask_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg   <= serial_port_irq_dma_pkg::APB_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            phase_reg   <= phase_next;
            pready_reg  <= ack_now;
            pslverr_reg <= ack_now && !mapped;
            prdata_reg  <= (ack_now && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_en_reg <= 1'b0;
            wid_reg     <= `SPC_RST_WID_M1;
        end else if (wr_commit && hit_ctrl) begin
            port_en_reg <= pwdata[`SPC_CTRL_EN_BIT];
            wid_reg     <= wid_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_reg  <= `SPC_RST_DMA;
            mask_reg <= `SPC_RST_MASK;
            raw_reg  <= '0;
        end else begin
            dma_reg <= dma_next;
            raw_reg <= raw_next;
            if (wr_commit && hit_mask) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end else begin
            busy_reg <= !(tx_fifo_empty && shift_empty);
            irq_reg  <= |masked;
        end
    end

    // upper bits of a transmit word are dropped here so the shifter never sees them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_word_reg  <= '0;
            tx_valid_reg <= 1'b0;
            rx_pop_reg   <= 1'b0;
        end else begin
            tx_valid_reg <= wr_commit && hit_tx;
            rx_pop_reg   <= rd_commit && hit_rx;
            if (wr_commit && hit_tx) begin
                tx_word_reg <= pwdata[WORD_W-1:0] & wmask;
            end
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign port_enable   = port_en_reg;
    assign width_m1      = wid_reg;
    assign rx_dma_enable = dma_reg.rx_dma_enable;
    assign tx_dma_enable = dma_reg.tx_dma_enable;
    assign busy          = busy_reg;
    assign irq           = irq_reg;
    assign tx_word       = tx_word_reg;
    assign tx_word_valid = tx_valid_reg;
    assign rx_word_pop   = rx_pop_reg;

    property p_dma_clear_named;
        @(posedge clk) disable iff (!arst_n)
        (wr_commit && hit_dma_clr)
        |=> (dma_reg == ($past(dma_reg) & ~$past(pwdata[1:0])));
    endproperty
    a_dma_clear_named: assert property (p_dma_clear_named)
        else $error("dma clear touched an unnamed enable");

    property p_dma_set_named;
        @(posedge clk) disable iff (!arst_n)
        (wr_commit && hit_dma_set)
        |=> (dma_reg == ($past(dma_reg) | $past(pwdata[1:0])));
    endproperty
    a_dma_set_named: assert property (p_dma_set_named)
        else $error("dma set did not or into enables");

    property p_port_enable;
        @(posedge clk) disable iff (!arst_n)
        (wr_commit && hit_ctrl) |=> (port_enable == $past(pwdata[0]));
    endproperty
    a_port_enable: assert property (p_port_enable)
        else $error("port enable did not follow control write");

    property p_event_sticky;
        @(posedge clk) disable iff (!arst_n)
        rx_timeout_evt ##1 !rx_timeout_evt && !(wr_commit && hit_clear)
        |=> raw_reg.rx_timeout_irq;
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("timeout status lost without clear");

    property p_clear_timeout;
        @(posedge clk) disable iff (!arst_n)
        (wr_commit && hit_clear && pwdata[`SPC_IRQ_RX_TIMEOUT] && !rx_timeout_evt)
        |=> !raw_reg.rx_timeout_irq;
    endproperty
    a_clear_timeout: assert property (p_clear_timeout)
        else $error("timeout status survived clear");

    property p_fifo_not_clearable;
        @(posedge clk) disable iff (!arst_n)
        (wr_commit && hit_clear)
        |=> (raw_reg.tx_fifo_service_irq == $past(tx_fifo_req))
            && (raw_reg.rx_fifo_service_irq == $past(rx_fifo_req));
    endproperty
    a_fifo_not_clearable: assert property (p_fifo_not_clearable)
        else $error("fifo status altered by clear");

    property p_mask_blocks;
        @(posedge clk) disable iff (!arst_n)
        (mask_reg == 4'h0) [*2] |-> !irq;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("irq high with all sources masked");

    property p_irq_from_masked;
        @(posedge clk) disable iff (!arst_n)
        (masked != 4'h0) |=> irq;
    endproperty
    a_irq_from_masked: assert property (p_irq_from_masked)
        else $error("irq low with unmasked source set");

    property p_busy_idle;
        @(posedge clk) disable iff (!arst_n)
        (tx_fifo_empty && shift_empty) [*2] |-> !busy;
    endproperty
    a_busy_idle: assert property (p_busy_idle)
        else $error("busy while fifo and shifter empty");

    property p_tx_width;
        @(posedge clk) disable iff (!arst_n)
        tx_word_valid |-> ((tx_word & ~wmask) == '0);
    endproperty
    a_tx_width: assert property (p_tx_width)
        else $error("tx word carries bits above width");

    property p_ready_pulse;
        @(posedge clk) disable iff (!arst_n)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held over two cycles");

endmodule // serial_port_irq_dma_ctrl

// ### tb/serial_datapath_model.sv
// behavioural stand-in for the shifter and fifos around the serial port irq/dma block
// assumes the bench steers the fifo requests and receive events through the cmd inputs
module serial_datapath_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        cmd_tx_req,
    input  wire logic        cmd_rx_req,
    input  wire logic        cmd_timeout,
    input  wire logic        cmd_overrun,
    input  wire logic        tx_word_valid,
    input  wire logic        rx_word_pop,
    output logic             tx_fifo_req,
    output logic             rx_fifo_req,
    output logic             rx_timeout_evt,
    output logic             rx_overrun_evt,
    output logic             tx_fifo_empty,
    output logic             shift_empty,
    output logic [15:0]      rx_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] drain_reg;

    assign tx_fifo_req    = cmd_tx_req;
    assign rx_fifo_req    = cmd_rx_req;
    assign rx_timeout_evt = cmd_timeout;
    assign rx_overrun_evt = cmd_overrun;
    // fifo empties well before the last bit leaves the shifter
    assign tx_fifo_empty  = (drain_reg < 4'h4);
    assign shift_empty    = (drain_reg == 4'h0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drain_reg <= 4'h0;
            rx_word   <= 16'h8b3d;
        end else begin
            if (tx_word_valid)
                drain_reg <= 4'h6;
            else if (drain_reg != 4'h0)
                drain_reg <= drain_reg - 4'h1;
            if (rx_word_pop)
                rx_word <= rx_word + 16'h1111;
        end
    end
endmodule // serial_datapath_model

// ### tb/test_serial_port_irq_dma_ctrl.sv
// self-checking bench for the serial port irq/dma block over apb
// assumes one 50 MHz clock and the datapath model on the far side
`include "serial_port_irq_dma_ctrl_cfg.svh"

module test_serial_port_irq_dma_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        c_tx, c_rx, c_to, c_or, txr, rxr, toe, ore, txe, she, pop, txv;
    logic        port_enable, rx_dma_enable, tx_dma_enable, busy, irq;
    logic [15:0] rx_word, tx_word, tx_seen;
    logic [3:0]  width_m1;
    int          err_count, checked;

    serial_port_irq_dma_ctrl dut_u (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_fifo_req(txr), .rx_fifo_req(rxr), .rx_timeout_evt(toe), .rx_overrun_evt(ore),
        .tx_fifo_empty(txe), .shift_empty(she), .rx_word(rx_word), .rx_word_pop(pop),
        .tx_word(tx_word), .tx_word_valid(txv), .port_enable(port_enable),
        .width_m1(width_m1), .rx_dma_enable(rx_dma_enable), .tx_dma_enable(tx_dma_enable),
        .busy(busy), .irq(irq));

    serial_datapath_model model_u (
        .clk(clk), .arst_n(arst_n), .cmd_tx_req(c_tx), .cmd_rx_req(c_rx),
        .cmd_timeout(c_to), .cmd_overrun(c_or), .tx_word_valid(txv), .rx_word_pop(pop),
        .tx_fifo_req(txr), .rx_fifo_req(rxr), .rx_timeout_evt(toe), .rx_overrun_evt(ore),
        .tx_fifo_empty(txe), .shift_empty(she), .rx_word(rx_word));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) if (txv === 1'b1) tx_seen <= tx_word;

    task automatic give_verdict();
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; waits on pready rather than assuming the wait state
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic e;
        apb(1'b0, a, 32'h0, rdv, e);
        chk(what, exp, rdv);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial begin
        logic e;
        err_count = 0; checked = 0; arst_n = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        c_tx = 1'b0; c_rx = 1'b0; c_to = 1'b0; c_or = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd("ctrl reset", `SPC_OFS_CTRL, 32'h70);
        rd("mask reset", `SPC_OFS_IRQ_MASK, 32'h0);
        rd("dma reset", `SPC_OFS_DMA_EN, 32'h0);
        // dma enables: set both, clear one, the other stays
        wr(`SPC_OFS_DMA_SET, 32'h3);
        rd("dma both", `SPC_OFS_DMA_EN, 32'h3);
        wr(`SPC_OFS_DMA_CLR, 32'h1);
        rd("dma clr rx", `SPC_OFS_DMA_EN, 32'h2);
        chk("dma pins", 32'h2, {30'h0, tx_dma_enable, rx_dma_enable});
        wr(`SPC_OFS_DMA_SET, 32'h1);
        wr(`SPC_OFS_DMA_CLR, 32'h2);
        rd("dma clr tx", `SPC_OFS_DMA_EN, 32'h1);
        wr(`SPC_OFS_DMA_EN, 32'h0);
        rd("dma direct", `SPC_OFS_DMA_EN, 32'h0);
        // width below the minimum clamps, then configure before enable
        wr(`SPC_OFS_CTRL, 32'h10);
        rd("width clamp", `SPC_OFS_CTRL, 32'h30);
        wr(`SPC_OFS_CTRL, 32'h70);
        wr(`SPC_OFS_CTRL, 32'h71);
        @(posedge clk);
        chk("enable pin", 32'h1, {31'h0, port_enable});
        chk("width pin", 32'h7, {28'h0, width_m1});
        rd("rx word 8b", `SPC_OFS_RX_DATA, 32'h3d);
        rd("rx word next", `SPC_OFS_RX_DATA, 32'h4e);
        wr(`SPC_OFS_TX_DATA, 32'habcd1234);
        rd("status busy", `SPC_OFS_STATUS, 32'h3);
        chk("busy pin on", 32'h1, {31'h0, busy});
        chk("tx word 8b", 32'h34, {16'h0, tx_seen});
        repeat (20) @(posedge clk);
        rd("status idle", `SPC_OFS_STATUS, 32'h2);
        chk("busy pin off", 32'h0, {31'h0, busy});
        wr(`SPC_OFS_CTRL, 32'hf1);
        wr(`SPC_OFS_TX_DATA, 32'habcd1234);
        settle();
        chk("tx word 16b", 32'h1234, {16'h0, tx_seen});
        wr(`SPC_OFS_CTRL, 32'hf0);
        rd("status off", `SPC_OFS_STATUS, 32'h0);
        // unmapped place and read-only place
        apb(1'b0, 12'h100, 32'h0, rdv, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rdv);
        wr(`SPC_OFS_IRQ_RAW, 32'hf);
        rd("raw ro", `SPC_OFS_IRQ_RAW, 32'h0);
        // sticky events, masking, write-one clear
        @(posedge clk);
        c_to <= 1'b1; c_or <= 1'b1;
        @(posedge clk);
        c_to <= 1'b0; c_or <= 1'b0;
        rd("raw events", `SPC_OFS_IRQ_RAW, 32'hc);
        rd("masked none", `SPC_OFS_IRQ_MASKED, 32'h0);
        chk("irq masked off", 32'h0, {31'h0, irq});
        wr(`SPC_OFS_IRQ_MASK, 32'h4);
        settle();
        chk("irq on", 32'h1, {31'h0, irq});
        rd("masked to", `SPC_OFS_IRQ_MASKED, 32'h4);
        wr(`SPC_OFS_IRQ_CLEAR, 32'h4);
        rd("raw after clr", `SPC_OFS_IRQ_RAW, 32'h8);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        c_tx <= 1'b1;
        wr(`SPC_OFS_IRQ_MASK, 32'h1);
        wr(`SPC_OFS_IRQ_CLEAR, 32'hb);
        rd("raw level kept", `SPC_OFS_IRQ_RAW, 32'h1);
        rd("mask rw", `SPC_OFS_IRQ_MASK, 32'h1);
        chk("irq tx level", 32'h1, {31'h0, irq});
        c_tx <= 1'b0;
        c_rx <= 1'b1;
        wr(`SPC_OFS_IRQ_MASK, 32'h2);
        rd("masked rx", `SPC_OFS_IRQ_MASKED, 32'h2);
        c_rx <= 1'b0;
        wr(`SPC_OFS_IRQ_MASK, 32'hf);
        settle();
        chk("irq idle", 32'h0, {31'h0, irq});
        give_verdict();
    end
endmodule // test_serial_port_irq_dma_ctrl
